// File: rtl/prepit_pkg.sv
// constants shared by the pre-pit block framer and its fifo
package prepit_pkg;
	localparam int FRAMES_PER_BLOCK = 16;
	localparam int FRAME_WORD_W = 13;
	localparam int MAKER_BYTES_TOTAL = 18;
	localparam int MAKER_BYTES_PER_BLOCK = 6;
	// frame numbers inside a block
	localparam logic [3:0] FRM_ADDR_FIRST = 4'h0;
	localparam logic [3:0] FRM_ADDR_LAST = 4'h2;
	localparam logic [3:0] FRM_PAR_A_LAST = 4'h5;
	localparam logic [3:0] FRM_KIND_ID = 4'h6;
	localparam logic [3:0] FRM_MAKER_FIRST = 4'h7;
	localparam logic [3:0] FRM_MAKER_LAST = 4'hc;
	localparam logic [3:0] FRM_PAR_B_FIRST = 4'hd;
	localparam logic [3:0] FRM_LAST = 4'hf;
	// frame word layout: bit 12 = position 0, [11:8] = positions 1..4, [7:0] = 5..12
	localparam int POS_SYNC = 12;
	localparam int POS_NUM_HI = 11;
	localparam int POS_NUM_LO = 8;
	// block kind identifier values
	localparam logic [7:0] KIND_ID_BASE = 8'h03;
	localparam logic [1:0] KIND_COUNT = 2'h3;
	// address map, ecc block addresses and physical sectors
	localparam logic [23:0] PCAL_FIRST_BLK = 24'h00_2080;
	localparam logic [23:0] PCAL_LAST_BLK = 24'h00_223a;
	localparam logic [23:0] RINFO_FIRST_BLK = 24'h00_2080;
	localparam logic [23:0] RINFO_LAST_BLK = 24'h00_2fff;
	localparam logic [23:0] RINFO_FIRST_SECTOR = 24'h02_0800;
	localparam logic [12:0] PCAL_SECTORS = 13'h1bb0;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} frm_state_t;
endpackage : prepit_pkg

// File: rtl/prepit_fifo.sv
// small synchronous fifo for framed words
`timescale 1ns/100ps
module prepit_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign in_ready = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign push = clk_en && in_valid && in_ready;
	assign pop = clk_en && out_valid && out_ready;
	// storage is a register array, so read data comes straight from flops
	assign out_data = mem_r[rd_ptr_r];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule : prepit_fifo

// File: rtl/prepit_block_format.sv
// pre-pit block framer for kinds 3..5, address decode and calibration sector count
//
// What this block does
// - frame 0 carries the sync marker at position 0, forming the physical block.
// - frames 0-2 send the block address msb first, frames 3-5 first check group.
// - third kind block: frame 6 holds identifier 03, frames 7-12 maker bytes 1-6.
// - fourth kind block: frame 6 holds identifier 04, frames 7-12 maker bytes 7-12.
// - fifth kind block: frame 6 holds identifier 05, frames 7-12 maker bytes 13-18.
// - frames 13, 14, 15 carry second check group bytes one, two, three.
// - recording info zone runs from sector 020800 up to block 02FFF.
// - block addresses 002080 through 00223A inclusive are flagged as calibration.
// - calibration region holds 7088 sectors; counter spans all of them.
`timescale 1ns/100ps
module prepit_block_format #(
	parameter int FIFO_W = prepit_pkg::FRAME_WORD_W,
	parameter int FIFO_D = prepit_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic start,
	input wire logic [1:0] block_kind,
	input wire logic [23:0] ecc_addr,
	input wire logic [23:0] parity_a,
	input wire logic [23:0] parity_b,
	input wire logic [8*prepit_pkg::MAKER_BYTES_TOTAL-1:0] maker_code_bytes,
	output logic busy,
	output logic frame_valid,
	input wire logic frame_ready,
	output logic [FIFO_W-1:0] frame_word,
	input wire logic [23:0] lookup_addr,
	output logic in_power_cal_region,
	output logic in_record_info_zone,
	input wire logic cal_consume,
	input wire logic cal_restart,
	output logic [12:0] cal_sectors_left,
	output logic cal_exhausted,
	output logic [23:0] cal_next_sector
);
	import prepit_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// framing state

	frm_state_t state_r;
	frm_state_t state_nxt;
	logic [3:0] frame_num_r;
	logic [1:0] kind_r;
	logic [23:0] addr_r;
	logic [23:0] par_a_r;
	logic [23:0] par_b_r;
	logic [8*MAKER_BYTES_PER_BLOCK-1:0] maker_r;
	logic [8*MAKER_BYTES_PER_BLOCK-1:0] maker_pick;
	logic [7:0] frame_byte;
	// kept 4 bits like frame_num_r; each branch but frame 6 subtracts its first frame, so frame 4 minus 3 gives offset 1 and none goes below zero
	logic [3:0] field_off;
	logic [FIFO_W-1:0] word_nxt;
	logic push_ok;
	logic push;
	logic start_ok;

	// a start with kind 3 or while busy is dropped rather than queued
	assign start_ok = clk_en && start && (state_r == ST_IDLE) && (block_kind < KIND_COUNT);
	assign push = clk_en && (state_r == ST_SEND) && push_ok;
	assign busy = (state_r != ST_IDLE);

	// only the six maker bytes of this kind are kept; contents never inspected
	always_comb begin
		maker_pick = '0;
		case (block_kind)
			2'd0: maker_pick = maker_code_bytes[143:96];
			2'd1: maker_pick = maker_code_bytes[95:48];
			2'd2: maker_pick = maker_code_bytes[47:0];
			default: maker_pick = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			kind_r <= '0;
			addr_r <= '0;
			par_a_r <= '0;
			par_b_r <= '0;
			maker_r <= '0;
		end else if (start_ok) begin
			kind_r <= block_kind;
			addr_r <= ecc_addr;
			par_a_r <= parity_a;
			par_b_r <= parity_b;
			maker_r <= maker_pick;
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_ok) begin
					state_nxt = ST_SEND;
				end
			end
			ST_SEND: begin
				if (push && frame_num_r == FRM_LAST) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			frame_num_r <= FRM_ADDR_FIRST;
		end else if (start_ok) begin
			frame_num_r <= FRM_ADDR_FIRST;
		end else if (push) begin
			frame_num_r <= frame_num_r + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frame content

	// each multi-byte field goes out most significant byte first
	always_comb begin
		frame_byte = 8'h00;
		field_off = 4'h0;
		if (frame_num_r <= FRM_ADDR_LAST) begin
			field_off = frame_num_r - FRM_ADDR_FIRST;
			frame_byte = addr_r[23 - 8*field_off[1:0] -: 8];
		end else if (frame_num_r <= FRM_PAR_A_LAST) begin
			field_off = frame_num_r - (FRM_ADDR_LAST + 4'h1);
			frame_byte = par_a_r[23 - 8*field_off[1:0] -: 8];
		end else if (frame_num_r == FRM_KIND_ID) begin
			frame_byte = KIND_ID_BASE + {6'h00, kind_r};
		end else if (frame_num_r <= FRM_MAKER_LAST) begin
			field_off = frame_num_r - FRM_MAKER_FIRST;
			frame_byte = maker_r[47 - 8*field_off[2:0] -: 8];
		end else begin
			field_off = frame_num_r - FRM_PAR_B_FIRST;
			frame_byte = par_b_r[23 - 8*field_off[1:0] -: 8];
		end
	end

	always_comb begin
		word_nxt = '0;
		word_nxt[POS_SYNC] = (frame_num_r == FRM_ADDR_FIRST);
		word_nxt[POS_NUM_HI:POS_NUM_LO] = frame_num_r;
		word_nxt[7:0] = frame_byte;
	end

	// fifo back-pressure stalls the frame counter, so no frame is skipped
	prepit_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_D)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.in_valid(state_r == ST_SEND),
		.in_ready(push_ok),
		.in_data(word_nxt),
		.out_valid(frame_valid),
		.out_ready(frame_ready),
		.out_data(frame_word)
	);

	////////////////////////////////////////////////////////////////////////////
	// address decode, registered so the compare chain stays off the output

	always_ff @(posedge clk) begin
		if (reset) begin
			in_power_cal_region <= 1'b0;
			in_record_info_zone <= 1'b0;
		end else if (clk_en) begin
			in_power_cal_region <= (lookup_addr >= PCAL_FIRST_BLK) &&
				(lookup_addr <= PCAL_LAST_BLK);
			in_record_info_zone <= (lookup_addr >= RINFO_FIRST_BLK) &&
				(lookup_addr <= RINFO_LAST_BLK);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// calibration sector accounting, outermost sector handed out first
	// restart beats consume: a fresh session begins at the outer end again

	always_ff @(posedge clk) begin
		if (reset) begin
			cal_sectors_left <= PCAL_SECTORS;
		end else if (clk_en) begin
			if (cal_restart) begin
				cal_sectors_left <= PCAL_SECTORS;
			end else if (cal_consume && cal_sectors_left != 13'h0000) begin
				cal_sectors_left <= cal_sectors_left - 13'h0001;
			end
		end
	end

	assign cal_exhausted = (cal_sectors_left == 13'h0000);

	// one past the last sector when exhausted; check cal_exhausted first
	always_ff @(posedge clk) begin
		if (reset) begin
			cal_next_sector <= RINFO_FIRST_SECTOR + {11'h000, PCAL_SECTORS} - 24'h00_0001;
		end else if (clk_en) begin
			cal_next_sector <= RINFO_FIRST_SECTOR + {11'h000, cal_sectors_left} -
				24'h00_0001;
		end
	end
endmodule : prepit_block_format

// File: verification/prepit_chk_sva.sv
// port assertions for the pre-pit block framer
`timescale 1ns/100ps
module prepit_chk #(
	parameter int FIFO_W = 13
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic start,
	input wire logic [1:0] block_kind,
	input wire logic busy,
	input wire logic frame_valid,
	input wire logic frame_ready,
	input wire logic [FIFO_W-1:0] frame_word,
	input wire logic [23:0] lookup_addr,
	input wire logic in_power_cal_region,
	input wire logic in_record_info_zone,
	input wire logic cal_consume,
	input wire logic cal_restart,
	input wire logic [12:0] cal_sectors_left,
	input wire logic cal_exhausted,
	input wire logic [23:0] cal_next_sector
);
	wire pcal = lookup_addr >= 24'h00_2080 && lookup_addr <= 24'h00_223a;
	wire zone = lookup_addr >= 24'h00_2080 && lookup_addr <= 24'h00_2fff;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	a_pcal_flag: assert property (clk_en |=> in_power_cal_region == $past(pcal))
		else $error("calibration flag wrong");
	a_zone_flag: assert property (clk_en |=> in_record_info_zone == $past(zone))
		else $error("zone flag wrong");
	a_empty_flag: assert property (cal_exhausted == (cal_sectors_left == 13'h0000))
		else $error("exhausted flag wrong");
	a_consume_step: assert property (clk_en && cal_consume && !cal_restart && !cal_exhausted
		|=> cal_sectors_left == $past(cal_sectors_left) - 13'h0001) else $error("no step");
	a_restart_load: assert property (clk_en && cal_restart |=> cal_sectors_left == 13'h1bb0)
		else $error("reload wrong");
	a_next_sector: assert property (clk_en |=> cal_next_sector ==
		24'h02_0800 + 24'($past(cal_sectors_left)) - 24'h00_0001) else $error("next sector");
	a_sync_marker: assert property (frame_valid |-> frame_word[12] == (frame_word[11:8] == 0))
		else $error("sync marker misplaced");
	a_start_busy: assert property (clk_en && start && !busy && block_kind != 2'h3
		|=> busy [*8]) else $error("busy too short");
	a_word_hold: assert property (frame_valid && !(frame_ready && clk_en)
		|=> frame_valid && $stable(frame_word)) else $error("word not held");
	a_kind_refused: assert property (clk_en && start && !busy && block_kind == 2'h3
		|=> !busy) else $error("kind 3 taken");
	a_zero_hold: assert property (clk_en && cal_consume && !cal_restart && cal_exhausted
		|=> cal_exhausted) else $error("count wrapped");
	c_stall: cover property (frame_valid && !frame_ready);
	c_block: cover property (clk_en && start && !busy);
	c_empty: cover property (cal_exhausted);
	c_pcal: cover property (in_power_cal_region);
endmodule : prepit_chk

bind prepit_block_format prepit_chk #(.FIFO_W(FIFO_W)) u_chk (.clk(clk), .reset(reset),
	.clk_en(clk_en), .start(start), .block_kind(block_kind), .busy(busy),
	.frame_valid(frame_valid), .frame_ready(frame_ready), .frame_word(frame_word),
	.lookup_addr(lookup_addr),
	.in_power_cal_region(in_power_cal_region), .in_record_info_zone(in_record_info_zone),
	.cal_consume(cal_consume), .cal_restart(cal_restart), .cal_sectors_left(cal_sectors_left),
	.cal_exhausted(cal_exhausted), .cal_next_sector(cal_next_sector));

// File: verification/frame_sink.sv
// frame consumer model, prompt, slow or stalled
`timescale 1ns/100ps
module frame_sink (
	input wire logic clk,
	input wire logic reset,
	input wire logic stall,
	input wire logic slow,
	output logic frame_ready
);
	logic phase_r;
	always_ff @(posedge clk) begin
		phase_r <= reset ? 1'b0 : ~phase_r;
	end
	// takes words only, maker bytes never looked at
	assign frame_ready = !stall && (!slow || phase_r);
endmodule : frame_sink

// File: verification/tb_prepit_block_format.sv
// self-checking bench for the pre-pit block framer
`timescale 1ns/100ps
module tb_prepit_block_format;
	logic clk = 0, reset = 1, clk_en = 1, start = 0, cal_consume = 0, cal_restart = 0;
	logic stall = 0, slow = 0, frame_ready, busy, frame_valid, pc, rz, cal_exhausted;
	logic [1:0] block_kind = 0;
	logic [23:0] ecc_addr = 24'h01_2345, parity_a = 24'h3c_5a7e, parity_b = 24'hc3_a581;
	logic [23:0] lookup_addr = 0, cal_next_sector;
	logic [143:0] maker = 144'h0102_0304_0506_0708_090a_0b0c_0d0e_0f10_1112;
	logic [12:0] frame_word, cal_sectors_left;
	logic [12:0] got[$];
	int n_fail = 0, comparisons = 0;
	always #10 clk = ~clk;
	prepit_block_format u_dut (.clk(clk), .reset(reset), .clk_en(clk_en), .start(start),
		.block_kind(block_kind), .ecc_addr(ecc_addr), .parity_a(parity_a), .parity_b(parity_b),
		.maker_code_bytes(maker), .busy(busy), .frame_valid(frame_valid),
		.frame_ready(frame_ready), .frame_word(frame_word), .lookup_addr(lookup_addr),
		.in_power_cal_region(pc), .in_record_info_zone(rz), .cal_consume(cal_consume),
		.cal_restart(cal_restart), .cal_sectors_left(cal_sectors_left),
		.cal_exhausted(cal_exhausted), .cal_next_sector(cal_next_sector));
	frame_sink u_sink (.clk(clk), .reset(reset), .stall(stall), .slow(slow),
		.frame_ready(frame_ready));
	always @(posedge clk) begin
		if (frame_valid && frame_ready && clk_en && !reset) begin
			got.push_back(frame_word);
		end
	end
	////////////////////////////////////////
	task chk(input logic [23:0] g, input logic [23:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask : chk
	task test_done;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	////////////////////////////////////////
	task t_block(input logic [1:0] k);
		logic [7:0] b;
		got.delete();
		@(posedge clk) begin block_kind <= k; start <= 1; end
		@(posedge clk) start <= 0;
		// stalled sink: fifo fills and holds the framer
		repeat (24) @(posedge clk);
		start <= 1;
		@(posedge clk) start <= 0;
		#1 chk(busy, 1, "fifo full");
		chk(got.size(), 0, "stalled sink popped");
		chk(frame_valid, 1, "stalled sink valid");
		stall <= 0;
		repeat (80) if (got.size() < 16) @(posedge clk);
		repeat (4) @(posedge clk);
		#1 chk(got.size(), 16, "count");
		chk(busy, 0, "start while busy taken");
		for (int i = 0; i < 16; i++) begin
			if (i < 3) b = ecc_addr[23-8*i -: 8];
			else if (i < 6) b = parity_a[47-8*i -: 8];
			else if (i == 6) b = 8'h03 + k;
			else if (i < 13) b = maker[199-8*(6*k+i) -: 8];
			else b = parity_b[127-8*i -: 8];
			chk(got[i], {i == 0, 4'(i), b}, "frame");
		end
	endtask : t_block
	task t_decode;
		logic [23:0] a;
		for (int i = 0; i < 6; i++) begin
			a = i[0] ? 24'h00_2080 : 24'h00_207f;
			a = i < 2 ? a : i < 4 ? a + 24'h00_01bb : a + 24'h00_0f80;
			@(posedge clk) lookup_addr <= a;
			@(posedge clk) #1;
			chk(pc, a >= 24'h00_2080 && a <= 24'h00_223a, "pcal");
			chk(rz, a >= 24'h00_2080 && a <= 24'h00_2fff, "zone");
		end
	endtask : t_decode
	task t_refuse;
		@(posedge clk) begin block_kind <= 2'h3; start <= 1; end
		@(posedge clk) start <= 0;
		@(posedge clk) #1 chk(busy, 0, "kind 3 taken");
		chk(frame_valid, 0, "kind 3 framed");
	endtask : t_refuse
	task t_cal;
		#1 chk(cal_sectors_left, 13'h1bb0, "cal reset");
		chk(cal_next_sector, 24'h02_23af, "next reset");
		@(posedge clk) begin cal_consume <= 1; clk_en <= 0; end
		@(posedge clk) clk_en <= 1;
		@(posedge clk) cal_consume <= 0;
		@(posedge clk) #1 chk(cal_sectors_left, 13'h1baf, "one sector");
		chk(cal_next_sector, 24'h02_23ae, "descend");
		@(posedge clk) cal_consume <= 1;
		repeat (7090) @(posedge clk);
		cal_consume <= 0;
		#1 chk(cal_exhausted, 1, "exhaust");
		@(posedge clk) begin cal_restart <= 1; cal_consume <= 1; end
		@(posedge clk) begin cal_restart <= 0; cal_consume <= 0; end
		#1 chk(cal_sectors_left, 13'h1bb0, "restart");
	endtask : t_cal
	////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		t_cal;
		t_decode;
		t_refuse;
		stall <= 1;
		t_block(2'h0);
		stall <= 1;
		slow <= 1;
		t_block(2'h1);
		stall <= 1;
		t_block(2'h2);
		test_done;
	end
	initial begin
		#1_000_000;
		n_fail++;
		test_done;
	end
endmodule : tb_prepit_block_format
